//--- fppr_top.sv
// Serial flash protocol configuration and sector protection registers
//
// Contract
// - Config register reached only by its own read and write commands.
// - After either config command, copy register into internal settings.
// - Bit 7 low selects four-wire command input; default high.
// - Bit 6 low selects two-wire command input; default high.
// - Bit 5 low selects double transfer rate; default single rate.
// - Bit 4 high enables hold/reset on data line three; default high.
// - Bits 2:0 drive codes 1,3,5,7 valid; default 7; bit 3 zero.
// - Both protocol bits low means four-wire wins over two-wire.
// - New protocol applies right after the config write completes.
// - Default protocol returns on reset, rescue, or another config write; a rescue in the same cycle as a config write is lost to the write.
// - Protection register 16 bits; only bits 2,1 active, others one.
// - One nonvolatile and one volatile lock bit per 64KB sector.
// - First and last sectors lock volatilely per 4KB subsector.
// - Clearing bit 2 enables password mode; password then hidden, fixed.
// - Clearing bit 1 disables password mode forever; bit 2 stays one.
// - Bits 2 and 1 are one-time; at most one may be cleared.
// - Password must be set before bit 2; afterwards changes refused.
// - In password mode only the right password sets freeze bit again.
// - Freeze bit one allows nonvolatile lock bit changes; zero blocks them.
// - In password mode freeze bit is locked at reset.
// - Freeze write clears the bit, freeze read returns it.
`timescale 1ns/1ps
module fppr_top
   import fppr_pkg::*;
#(
   parameter int SECTORS = 1024
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic PWR_ON,
   input wire logic LINK_SCK,
   input wire logic CHIP_SEL_N,
   input wire logic DATA_IN,
   input wire logic RESCUE_SEQ,
   input wire logic [ADDR_W-1:0] QUERY_ADDR,
   output logic DATA_OUT,
   output logic DATA_OE,
   output logic QUAD_IO,
   output logic DUAL_IO,
   output logic DOUBLE_RATE,
   output logic HOLD_RESET_EN,
   output logic [2:0] DRIVE_CODE,
   output logic PASSWORD_MODE,
   output logic NV_LOCK_WRITABLE,
   output logic SECTOR_PROTECTED,
   output logic CMD_DONE,
   output logic CMD_REFUSED
);
   localparam int SEC_W = $clog2(SECTORS);
   localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SECTORS - 1);

   // ---------------- Link clock domain ----------------
   logic first_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q;
   fppr_frame_s frm_q;
   logic rd_q;
   logic [63:0] resp_q;
   logic [5:0] oidx_q;
   fppr_snap_s snap_q;
   logic [2:0] bit_c;
   logic [7:0] sh_c;
   logic [3:0] cnt_c;
   logic byte_done;

   // Reply word for a read opcode
   function automatic logic [63:0] pick(input logic [7:0] op,
                                        input fppr_snap_s s);
      logic [63:0] r;
      r = 64'h0;
      case (op)
         OP_RD_CFG: r = {s.cfg, 56'h0};
         OP_RD_SPR: r = {s.spr, 48'h0};
         OP_RD_FRZ: r = {7'h0, s.frz, 56'h0};
         OP_RD_PWD: r = s.spr[SPR_PWD] ? s.pwd : PWD_RST;
         default: r = 64'h0;
      endcase
      return r;
   endfunction : pick

   function automatic logic is_read(input logic [7:0] op);
      return (op == OP_RD_CFG) || (op == OP_RD_SPR) ||
             (op == OP_RD_FRZ) || (op == OP_RD_PWD);
   endfunction : is_read

   // Frame start marker, set while chip select is high
   always_ff @(posedge LINK_SCK or posedge CHIP_SEL_N) begin
      if (CHIP_SEL_N) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   // Counters restart on the first edge of each frame
   always_comb begin
      bit_c = first_q ? 3'h0 : bit_q;
      cnt_c = first_q ? 4'h0 : frm_q.cnt;
      sh_c = {sh_q[6:0], DATA_IN};
      byte_done = (bit_c == 3'h7);
   end

   // Bit shifting and byte assembly; frame held once the clock stops
   always_ff @(posedge LINK_SCK) begin
      bit_q <= bit_c + 3'h1;
      sh_q <= sh_c;
      if (byte_done) begin
         if (cnt_c == 4'h0) begin
            frm_q.op <= sh_c;
         end else begin
            frm_q.dat <= {frm_q.dat[55:0], sh_c};
         end
         frm_q.cnt <= (cnt_c == N_MAX) ? N_MAX : cnt_c + 4'h1;
      end else begin
         frm_q.cnt <= cnt_c;
      end
   end

   // Reply selection once the opcode is in
   always_ff @(posedge LINK_SCK) begin
      if (byte_done && cnt_c == 4'h0) begin
         rd_q <= is_read(sh_c);
         resp_q <= pick(sh_c, snap_q);
      end else if (first_q) begin
         rd_q <= 1'b0;
      end
   end

   // Reply shifted out on falling edges, released when deselected
   always_ff @(negedge LINK_SCK or posedge CHIP_SEL_N) begin
      if (CHIP_SEL_N) begin
         DATA_OE <= 1'b0;
         DATA_OUT <= 1'b0;
         oidx_q <= 6'h3f;
      end else if (rd_q) begin
         DATA_OE <= 1'b1;
         DATA_OUT <= resp_q[oidx_q];
         oidx_q <= oidx_q - 6'h1;
      end
   end

   // ---------------- Core clock domain ----------------
   logic rst_any;
   logic cs_meta_q;
   logic cs_sync_q;
   logic rs_meta_q;
   logic rs_sync_q;
   logic rs_prev_q;
   logic rescue;
   fppr_state_e st_q;
   logic [7:0] cfg_q;
   logic [7:0] act_q;
   logic dl_q;
   logic [15:0] spr_q;
   logic [63:0] pwd_q;
   logic frz_q;
   logic [SECTORS-1:0] nvl_q;
   logic [SECTORS-1:0] vl_q;
   logic [(1<<SUB_W)-1:0] subf_q;
   logic [(1<<SUB_W)-1:0] subl_q;

   assign rst_any = RESET | PWR_ON;

   // Two-stage synchronisers for chip select and rescue pin
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         cs_meta_q <= 1'b1;
         cs_sync_q <= 1'b1;
         rs_meta_q <= 1'b0;
         rs_sync_q <= 1'b0;
         rs_prev_q <= 1'b0;
      end else begin
         cs_meta_q <= CHIP_SEL_N;
         cs_sync_q <= cs_meta_q;
         rs_meta_q <= RESCUE_SEQ;
         rs_sync_q <= rs_meta_q;
         rs_prev_q <= rs_sync_q;
      end
   end

   assign rescue = rs_sync_q & ~rs_prev_q;

   // Frame tracking: a frame executes once chip select is seen high
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         st_q <= ST_IDLE;
      end else begin
         unique case (st_q)
            ST_IDLE: st_q <= cs_sync_q ? ST_IDLE : ST_FRAME;
            ST_FRAME: st_q <= cs_sync_q ? ST_EXEC : ST_FRAME;
            ST_EXEC: st_q <= ST_SHOW;
            ST_SHOW: st_q <= ST_IDLE;
         endcase
      end
   end

   // Command decode; the held frame is stable while deselected
   logic ex;
   logic [7:0] op;
   logic [3:0] cnt;
   logic [63:0] dat;
   logic [15:0] spr_new;
   logic [7:0] cfg_new;
   logic [SEC_W-1:0] nsec;
   logic [SEC_W-1:0] vsec;
   logic [SUB_W-1:0] vsub;
   logic wr_cfg;
   logic rd_cmd;
   logic wr_spr;
   logic wr_pwd;
   logic unlock;
   logic wr_frz;
   logic wr_nvl;
   logic er_nvl;
   logic wr_vl;
   logic good;

   always_comb begin
      ex = (st_q == ST_EXEC);
      op = frm_q.op;
      cnt = frm_q.cnt;
      dat = frm_q.dat;
      spr_new = spr_q & (dat[15:0] | SPR_FIXED);
      cfg_new = {dat[7:4], 1'b0,
                 dat[CFG_DRV] ? dat[2:0] : cfg_q[2:0]};
      nsec = dat[SEC_LSB +: SEC_W];
      vsec = dat[VLK_ADR + SEC_LSB +: SEC_W];
      vsub = dat[VLK_ADR + SUB_LSB +: SUB_W];
      wr_cfg = ex && op == OP_WR_CFG && cnt == N_CFG;
      rd_cmd = ex && is_read(op) && cnt != 4'h0;
      wr_spr = ex && op == OP_WR_SPR && cnt == N_SPR &&
               (spr_new[SPR_PWD] | spr_new[SPR_SPL]);
      wr_pwd = ex && op == OP_WR_PWD && cnt == N_PWD &&
               spr_q[SPR_PWD];
      unlock = ex && op == OP_UNLOCK && cnt == N_PWD &&
               dat == pwd_q;
      wr_frz = ex && op == OP_WR_FRZ && cnt != 4'h0;
      wr_nvl = ex && op == OP_WR_NVL && cnt == N_ADDR && frz_q;
      er_nvl = ex && op == OP_ER_NVL && cnt != 4'h0 && frz_q;
      wr_vl = ex && op == OP_WR_VL && cnt == N_VLK;
      good = wr_cfg | rd_cmd | wr_spr | wr_pwd | unlock | wr_frz |
             wr_nvl | er_nvl | wr_vl;
   end

   // Configuration register and its rescue path
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         cfg_q <= CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= cfg_new;
      end else if (rescue) begin
         cfg_q[CFG_QUAD:CFG_DTR] <= PROTO_DFLT;
      end
   end

   // Download flag for the settings copy
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         dl_q <= 1'b0;
      end else if (ex) begin
         dl_q <= wr_cfg | (rd_cmd && op == OP_RD_CFG);
      end
   end

   // Internal settings loaded after a config command completes
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         act_q <= CFG_RST;
      end else if (rescue) begin
         act_q[CFG_QUAD:CFG_DTR] <= PROTO_DFLT;
      end else if (st_q == ST_SHOW && dl_q) begin
         act_q <= cfg_q;
      end
   end

   // Nonvolatile protection mode bits, one-time clear only
   always_ff @(posedge CORE_CLK) begin
      if (PWR_ON) begin
         spr_q <= SPR_RST;
      end else if (wr_spr) begin
         spr_q <= spr_new;
      end
   end

   // Password storage, frozen once password mode is on
   always_ff @(posedge CORE_CLK) begin
      if (PWR_ON) begin
         pwd_q <= PWD_RST;
      end else if (wr_pwd) begin
         pwd_q <= dat;
      end
   end

   // Global freeze bit
   always_ff @(posedge CORE_CLK) begin
      if (PWR_ON) begin
         frz_q <= FRZ_RST;
      end else if (RESET) begin
         frz_q <= spr_q[SPR_PWD];
      end else if (unlock) begin
         frz_q <= 1'b1;
      end else if (wr_frz) begin
         frz_q <= 1'b0;
      end
   end

   // Nonvolatile lock bits, one per sector, zero means locked
   always_ff @(posedge CORE_CLK) begin
      if (PWR_ON) begin
         nvl_q <= '1;
      end else if (er_nvl) begin
         nvl_q <= '1;
      end else if (wr_nvl) begin
         nvl_q[nsec] <= 1'b0;
      end
   end

   // Volatile lock bits; end sectors use subsector bits
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         vl_q <= '0;
         subf_q <= '0;
         subl_q <= '0;
      end else if (wr_vl) begin
         if (vsec == '0) begin
            subf_q[vsub] <= dat[0];
         end else if (vsec == SEC_LAST) begin
            subl_q[vsub] <= dat[0];
         end else begin
            vl_q[vsec] <= dat[0];
         end
      end
   end

   // Register copy offered to the link, steady during frames
   always_ff @(posedge CORE_CLK) begin
      if (PWR_ON) begin
         snap_q <= '{cfg: CFG_RST, spr: SPR_RST, frz: FRZ_RST,
                     pwd: PWD_RST};
      end else if (st_q != ST_FRAME) begin
         snap_q <= '{cfg: cfg_q, spr: spr_q, frz: frz_q, pwd: pwd_q};
      end
   end

   // Protection lookup for the queried address
   logic [SEC_W-1:0] qsec;
   logic [SUB_W-1:0] qsub;
   logic vol_hit;

   always_comb begin
      qsec = QUERY_ADDR[SEC_LSB +: SEC_W];
      qsub = QUERY_ADDR[SUB_LSB +: SUB_W];
      if (qsec == '0) begin
         vol_hit = subf_q[qsub];
      end else if (qsec == SEC_LAST) begin
         vol_hit = subl_q[qsub];
      end else begin
         vol_hit = vl_q[qsec];
      end
   end

   // Registered outputs decoded from the internal settings and protection state
   always_ff @(posedge CORE_CLK) begin
      if (PWR_ON) begin
         QUAD_IO <= 1'b0;
         DUAL_IO <= 1'b0;
         DOUBLE_RATE <= 1'b0;
         HOLD_RESET_EN <= 1'b1;
         DRIVE_CODE <= CFG_RST[2:0];
         PASSWORD_MODE <= 1'b0;
         NV_LOCK_WRITABLE <= FRZ_RST;
         SECTOR_PROTECTED <= 1'b0;
      end else begin
         QUAD_IO <= ~act_q[CFG_QUAD];
         DUAL_IO <= act_q[CFG_QUAD] & ~act_q[CFG_DUAL];
         DOUBLE_RATE <= ~act_q[CFG_DTR];
         HOLD_RESET_EN <= act_q[CFG_HOLD];
         DRIVE_CODE <= act_q[2:0];
         PASSWORD_MODE <= ~spr_q[SPR_PWD];
         NV_LOCK_WRITABLE <= frz_q;
         SECTOR_PROTECTED <= ~nvl_q[qsec] | vol_hit;
      end
   end

   // Completion and refusal pulses
   always_ff @(posedge CORE_CLK) begin
      if (rst_any) begin
         CMD_DONE <= 1'b0;
         CMD_REFUSED <= 1'b0;
      end else begin
         CMD_DONE <= ex & good;
         CMD_REFUSED <= ex & ~good;
      end
   end
endmodule : fppr_top

//--- fppr_pkg.sv
// Constants, carriers and states for the protocol and protection registers
package fppr_pkg;
   // Command opcodes, values chosen freely for this block
   localparam logic [7:0] OP_RD_CFG = 8'h31;
   localparam logic [7:0] OP_WR_CFG = 8'h32;
   localparam logic [7:0] OP_RD_SPR = 8'h33;
   localparam logic [7:0] OP_WR_SPR = 8'h34;
   localparam logic [7:0] OP_WR_PWD = 8'h35;
   localparam logic [7:0] OP_RD_PWD = 8'h36;
   localparam logic [7:0] OP_UNLOCK = 8'h37;
   localparam logic [7:0] OP_RD_FRZ = 8'h38;
   localparam logic [7:0] OP_WR_FRZ = 8'h39;
   localparam logic [7:0] OP_WR_NVL = 8'h3a;
   localparam logic [7:0] OP_ER_NVL = 8'h3b;
   localparam logic [7:0] OP_WR_VL = 8'h3c;

   // Frame lengths in bytes, opcode included
   localparam logic [3:0] N_CFG = 4'h2;
   localparam logic [3:0] N_SPR = 4'h3;
   localparam logic [3:0] N_ADDR = 4'h5;
   localparam logic [3:0] N_VLK = 4'h6;
   localparam logic [3:0] N_PWD = 4'h9;
   localparam logic [3:0] N_MAX = 4'hf;

   // Configuration register fields and reset value
   localparam int CFG_QUAD = 7;
   localparam int CFG_DUAL = 6;
   localparam int CFG_DTR = 5;
   localparam int CFG_HOLD = 4;
   localparam int CFG_DRV = 0;
   localparam logic [7:0] CFG_RST = 8'hf7;
   localparam logic [2:0] PROTO_DFLT = 3'h7;

   // Protection register fields and reset values
   localparam int SPR_PWD = 2;
   localparam int SPR_SPL = 1;
   localparam logic [15:0] SPR_RST = 16'hffff;
   localparam logic [15:0] SPR_FIXED = 16'hfff9;
   localparam logic [63:0] PWD_RST = 64'hffff_ffff_ffff_ffff;
   localparam logic FRZ_RST = 1'b1;

   // Address layout
   localparam int ADDR_W = 26;
   localparam int SEC_LSB = 16;
   localparam int SUB_LSB = 12;
   localparam int SUB_W = 4;
   localparam int VLK_ADR = 8;

   // Register copy offered to the link side
   typedef struct packed {
      logic [7:0] cfg;
      logic [15:0] spr;
      logic frz;
      logic [63:0] pwd;
   } fppr_snap_s;

   // One captured frame
   typedef struct packed {
      logic [7:0] op;
      logic [63:0] dat;
      logic [3:0] cnt;
   } fppr_frame_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FRAME = 2'b01,
      ST_EXEC = 2'b10,
      ST_SHOW = 2'b11
   } fppr_state_e;
endpackage : fppr_pkg

//--- fppr_assertions.sv
// Port checker for the protocol and protection register block
`timescale 1ns/1ps
module fppr_assertions
   import fppr_pkg::*;
#(
   parameter int SECTORS = 1024
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic PWR_ON,
   input wire logic CHIP_SEL_N,
   input wire logic DATA_OE,
   input wire logic QUAD_IO,
   input wire logic DUAL_IO,
   input wire logic [2:0] DRIVE_CODE,
   input wire logic PASSWORD_MODE,
   input wire logic NV_LOCK_WRITABLE,
   input wire logic CMD_DONE,
   input wire logic CMD_REFUSED
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET || PWR_ON);

   // Answers come only after the frame has closed
   property p_after_cs; (CMD_DONE || CMD_REFUSED) |->
      CHIP_SEL_N && $past(CHIP_SEL_N, 3); endproperty
   a_after_cs: assert property (p_after_cs)
      else $error("answer while frame open");
   property p_pulse; (CMD_DONE || CMD_REFUSED) |=>
      !(CMD_DONE || CMD_REFUSED); endproperty
   a_pulse: assert property (p_pulse)
      else $error("answer longer than one cycle");
   property p_quad_wins; QUAD_IO |-> !DUAL_IO; endproperty
   a_quad_wins: assert property (p_quad_wins)
      else $error("two protocols at once");
   property p_drive_odd; DRIVE_CODE[0]; endproperty
   a_drive_odd: assert property (p_drive_odd)
      else $error("reserved drive code");
   property p_drive_cause; $changed(DRIVE_CODE) |-> $past(CMD_DONE)
      || $past(CMD_DONE, 2) || $past(CMD_DONE, 3) || $past(RESET)
      || $past(RESET, 2); endproperty
   a_drive_cause: assert property (p_drive_cause)
      else $error("drive code changed without command");
   property p_pwd_sticky; PASSWORD_MODE |=> PASSWORD_MODE; endproperty
   a_pwd_sticky: assert property (p_pwd_sticky)
      else $error("password mode left");
   property p_frz_reset; $fell(RESET) && PASSWORD_MODE
      |-> !NV_LOCK_WRITABLE; endproperty
   a_frz_reset: assert property (p_frz_reset)
      else $error("freeze open after reset");
   property p_oe_off; CHIP_SEL_N |-> !DATA_OE; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("driving while deselected");
   property p_unlock; $rose(NV_LOCK_WRITABLE) |-> $past(CMD_DONE)
      || $past(CMD_DONE, 2) || $past(RESET) || $past(RESET, 2);
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("freeze opened without command");

   // Main scenarios
   c_done: cover property (CMD_DONE);
   c_refused: cover property (CMD_REFUSED);
   c_quad: cover property ($rose(QUAD_IO));
endmodule : fppr_assertions

bind fppr_top fppr_assertions #(.SECTORS(SECTORS)) u_chk (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .PWR_ON(PWR_ON),
   .CHIP_SEL_N(CHIP_SEL_N), .DATA_OE(DATA_OE), .QUAD_IO(QUAD_IO),
   .DUAL_IO(DUAL_IO), .DRIVE_CODE(DRIVE_CODE),
   .PASSWORD_MODE(PASSWORD_MODE), .NV_LOCK_WRITABLE(NV_LOCK_WRITABLE),
   .CMD_DONE(CMD_DONE), .CMD_REFUSED(CMD_REFUSED));

//--- fppr_host.sv
// Serial host model issuing register command frames
`timescale 1ns/1ps
module fppr_host (
   output logic sck,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // Idle: clock still, deselected; opening deselect edge clears link flops
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      mosi = 1'b0;
      #1 cs_n = 1'b1;
   end

   // One frame of nb bytes, clocked on to 8+rn bits if longer, with rn reply bits taken on rises after the opcode byte
   task automatic frame(input int nb, input logic [71:0] tx,
         input int rn, output logic [63:0] rx);
      int n;
      n = (8 * nb > 8 + rn) ? 8 * nb : 8 + rn;
      rx = '0;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi = (i < 8 * nb) ? tx[71 - i] : ~mosi;
         #40 sck = 1'b1;
         if (i >= 8 && i < 8 + rn) rx = {rx[62:0], miso};
         #40 sck = 1'b0;
      end
      #40 cs_n = 1'b1;
      mosi = ~mosi;
      #160;
   endtask : frame
endmodule : fppr_host

//--- tb.sv
// Self-checking bench for the protocol and protection registers
`timescale 1ns/1ps
module tb;
   import fppr_pkg::*;
   localparam logic [63:0] PW = 64'h0123_4567_89ab_cdef;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pwr = 1'b1;
   logic resc = 1'b0;
   logic [ADDR_W-1:0] qa = '0;
   logic sck, cs_n, din, dout, doe, quad, dual, ddr, hold, pmode, nvw;
   logic sprot, done, refd;
   logic [2:0] drv;
   logic [63:0] rx;
   logic [15:0] seed = 16'h2ebd;
   logic [7:0] cfg;
   logic [7:0] tbl [8] = '{8'h3f, 8'h7f, 8'hbf, 8'hd9, 8'hc3, 8'hf5,
      8'hfe, 8'hff};
   int mismatches = 0;
   int total_checks = 0;
   int n_done = 0;
   int n_ref = 0;
   int n_oe = 0;

   always #10 clk = ~clk;
   // Count answer pulses and cycles with the reply driven
   always @(posedge clk) begin
      n_done += done;
      n_ref += refd;
      n_oe += doe;
   end

   fppr_host u_host (.sck(sck), .cs_n(cs_n), .mosi(din), .miso(dout));
   fppr_top DUT (.CORE_CLK(clk), .RESET(rst), .PWR_ON(pwr),
      .LINK_SCK(sck), .CHIP_SEL_N(cs_n), .DATA_IN(din), .RESCUE_SEQ(resc),
      .QUERY_ADDR(qa), .DATA_OUT(dout), .DATA_OE(doe), .QUAD_IO(quad),
      .DUAL_IO(dual), .DOUBLE_RATE(ddr), .HOLD_RESET_EN(hold),
      .DRIVE_CODE(drv), .PASSWORD_MODE(pmode), .NV_LOCK_WRITABLE(nvw),
      .SECTOR_PROTECTED(sprot), .CMD_DONE(done), .CMD_REFUSED(refd));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Expected settings outputs for a register value
   function automatic logic [6:0] setx(input logic [7:0] c);
      return {~c[7], c[7] & ~c[6], ~c[5], c[4], c[2:0]};
   endfunction : setx

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One frame, then a bounded wait for its answer pulse
   task automatic cmd(input int nb, input logic [71:0] tx, input int rn,
         input logic ok);
      int d0;
      int r0;
      int o0;
      d0 = n_done;
      r0 = n_ref;
      o0 = n_oe;
      #3;
      u_host.frame(nb, tx, rn, rx);
      for (int i = 0; i < 20 && n_done + n_ref == d0 + r0; i++)
         @(posedge clk);
      if (n_done + n_ref == d0 + r0) begin
         chk(64'h1, 64'h0);
         complete_run();
      end else begin
         chk({n_done - d0 == 1, n_ref - r0 == 1}, {ok, ~ok});
         chk(n_oe != o0, rn != 0);
         repeat (3) @(negedge clk);
      end
   endtask : cmd

   // Write config, compare settings and read back
   task automatic cfgw(input logic [7:0] w);
      if (w[0]) cfg[2:0] = w[2:0];
      cfg[7:3] = {w[7:4], 1'b0};
      cmd(2, {OP_WR_CFG, w, 56'h0}, 0, 1'b1);
      chk({quad, dual, ddr, hold, drv}, setx(cfg));
      cmd(1, {OP_RD_CFG, 64'h0}, 8, 1'b1);
      chk(rx, cfg);
   endtask : cfgw

   task automatic pulse(input logic p);
      pwr = p;
      rst = ~p;
      repeat (3) @(negedge clk);
      pwr = 1'b0;
      rst = 1'b0;
      repeat (3) @(negedge clk);
      cfg = CFG_RST;
   endtask : pulse

   task automatic q(input logic [ADDR_W-1:0] a, input logic e);
      qa = a;
      @(negedge clk);
      chk(sprot, e);
   endtask : q

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask : tend

   // Main sequence
   initial begin
      pulse(1'b1);
      chk({quad, dual, ddr, hold, drv}, setx(cfg));
      chk({pmode, nvw}, 2'b01);
      cmd(1, {OP_RD_SPR, 64'h0}, 16, 1'b1);
      chk(rx, SPR_RST);
      tend("defaults");
      foreach (tbl[i]) cfgw(tbl[i]);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         cfgw(seed[7:0]);
      end
      cmd(1, {8'h50, 64'h0}, 0, 1'b0);
      cmd(3, {OP_WR_CFG, 64'h0}, 0, 1'b0);
      cfgw(8'h1f);
      resc = 1'b1;
      repeat (6) @(negedge clk);
      resc = 1'b0;
      cfg[7:5] = 3'h7;
      chk({quad, dual, ddr, hold, drv}, setx(cfg));
      cfgw(8'h15);
      pulse(1'b0);
      chk({quad, dual, ddr, hold, drv}, setx(cfg));
      tend("config");
      cmd(5, {OP_WR_NVL, 32'h0002_0000, 32'h0}, 0, 1'b1);
      q(26'h002_0000, 1'b1);
      q(26'h003_0000, 1'b0);
      cmd(1, {OP_WR_FRZ, 64'h0}, 0, 1'b1);
      cmd(1, {OP_RD_FRZ, 64'h0}, 8, 1'b1);
      chk(nvw, 1'b0);
      chk(rx, 64'h0);
      cmd(1, {OP_ER_NVL, 64'h0}, 0, 1'b0);
      cmd(9, {OP_UNLOCK, PWD_RST}, 0, 1'b1);
      cmd(1, {OP_ER_NVL, 64'h0}, 0, 1'b1);
      q(26'h002_0000, 1'b0);
      cmd(6, {OP_WR_VL, 32'h0000_1000, 8'h01, 24'h0}, 0, 1'b1);
      q(26'h000_1000, 1'b1);
      q(26'h000_2000, 1'b0);
      cmd(6, {OP_WR_VL, 32'h03ff_3000, 8'h01, 24'h0}, 0, 1'b1);
      q(26'h3ff_3000, 1'b1);
      q(26'h3ff_4000, 1'b0);
      cmd(6, {OP_WR_VL, 32'h0005_0000, 8'h01, 24'h0}, 0, 1'b1);
      q(26'h005_0000, 1'b1);
      tend("locks");
      cmd(9, {OP_WR_PWD, PW}, 0, 1'b1);
      cmd(1, {OP_RD_PWD, 64'h0}, 64, 1'b1);
      chk(rx, PW);
      cmd(3, {OP_WR_SPR, 16'hfffb, 48'h0}, 0, 1'b1);
      cmd(1, {OP_RD_PWD, 64'h0}, 64, 1'b1);
      chk(pmode, 1'b1);
      chk(rx, 64'hffff_ffff_ffff_ffff);
      cmd(9, {OP_WR_PWD, 64'h0}, 0, 1'b0);
      cmd(3, {OP_WR_SPR, 16'hfffd, 48'h0}, 0, 1'b0);
      pulse(1'b0);
      chk(nvw, 1'b0);
      q(26'h000_1000, 1'b0);
      cmd(5, {OP_WR_NVL, 32'h0, 32'h0}, 0, 1'b0);
      cmd(9, {OP_UNLOCK, ~PW}, 0, 1'b0);
      cmd(9, {OP_UNLOCK, PW}, 0, 1'b1);
      chk(nvw, 1'b1);
      tend("password");
      pulse(1'b1);
      cmd(3, {OP_WR_SPR, 16'hfffd, 48'h0}, 0, 1'b1);
      cmd(3, {OP_WR_SPR, 16'hfffb, 48'h0}, 0, 1'b0);
      cmd(1, {OP_RD_SPR, 64'h0}, 16, 1'b1);
      chk(pmode, 1'b0);
      chk(rx, 64'hfffd);
      pulse(1'b0);
      chk(nvw, 1'b1);
      tend("no password");
      complete_run();
   end
endmodule : tb
